// File: core/pgt_pkg.sv
/*
  Package of the power-good tree and fault-mask register block: register offsets,
  field positions and reset values.
  Assumes an internal register port decoded from the serial host interface.
*/
package pgt_pkg;

  localparam logic [7:0] PGT_OFS_FAULT_MASK_B = 8'ha3;
  localparam logic [7:0] PGT_OFS_PG1_SEL_A    = 8'ha4;
  localparam logic [7:0] PGT_OFS_PG1_SEL_B    = 8'ha5;

  // Second fault-mask register fields.
  localparam int PGT_FM_RSVD_RO = 7;
  localparam int PGT_FM_RSVD6   = 6;
  localparam int PGT_FM_RSVD5   = 5;
  localparam int PGT_FM_A1      = 4;
  localparam int PGT_FM_TERM    = 3;
  localparam int PGT_FM_B2      = 2;
  localparam int PGT_FM_B1      = 1;
  localparam int PGT_FM_A3      = 0;

  // Second source-mask register fields.
  localparam int PGT_SB_CONTROL_INPUT_5   = 7;
  localparam int PGT_SB_CONTROL_INPUT_4   = 6;
  localparam int PGT_SB_CONTROL_INPUT_2   = 5;
  localparam int PGT_SB_CONTROL_INPUT_1   = 4;
  localparam int PGT_SB_TERM   = 3;
  localparam int PGT_SB_SHARED = 2;
  localparam int PGT_SB_B1     = 1;
  localparam int PGT_SB_A3     = 0;

  // Reserved bits 6 and 5 reset to 0 and 1; the rail masks reset to zero here.
  localparam logic [7:0] PGT_FAULT_MASK_B_RST = 8'h20;

  // Source-mask registers hold this until the default configuration is loaded.
  localparam logic [7:0] PGT_PG1_SEL_RST = 8'h00;

  // Rail good and fault indications, one bit per rail.
  typedef struct packed {
    logic       linear_reg_a2;
    logic       load_switch_a1;
    logic [5:0] step_down_rail;
    logic       linear_reg_a1;
    logic       ddr_term_reg;
    logic       load_switch_b2;
    logic       load_switch_b1;
    logic       linear_reg_a3;
  } pgt_rails_s;

  // Register write and read port.
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pgt_reg_req_s;

endpackage : pgt_pkg

// File: core/pgt_tree.sv
/*
  Fault-mask register B, the two source-mask registers of pg_output_1 and the
  gating logic behind them.
  Assumes the serial host interface presents decoded single-cycle register accesses,
  and that the default configuration supplies the source-mask reset values and
  the shared-rail selection.
*/
`timescale 1ns/1ps

module pgt_tree
  import pgt_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire pgt_reg_req_s reg_req,
  output logic        [7:0] reg_rdata,
  output logic              reg_rvalid,
  input  wire logic   [7:0] cfg_sel_a_default,
  input  wire logic   [7:0] cfg_sel_b_default,
  input  wire logic         cfg_shared_is_a1,
  input  wire pgt_rails_s   rail_good,
  input  wire pgt_rails_s   rail_fault,
  input  wire logic   [3:0] control_input,
  output logic              pg_output_1,
  output logic              shutdown_req
);

  logic       rst_meta_reg;
  logic       rst_sync_reg;
  logic       rst_n;
  logic       load_default_reg;
  logic [7:0] fault_shutdown_mask_b_reg;
  logic [7:0] pg1_rail_select_a_reg;
  logic [7:0] pg1_rail_select_b_reg;
  logic       shared_good;
  logic       shared_fault;
  logic [7:0] terms_a;
  logic [7:0] terms_b;
  logic [7:0] fault_b;
  logic       pg_next;
  logic       shutdown_next;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // The defaults are sampled by a clocked load in the first cycle after release.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      load_default_reg <= 1'b1;
    end else begin
      load_default_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fault_shutdown_mask_b_reg <= PGT_FAULT_MASK_B_RST;
    end else if (reg_req.wr_en && reg_req.addr == PGT_OFS_FAULT_MASK_B) begin
      fault_shutdown_mask_b_reg <= {1'b0, reg_req.wdata[6:0]};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pg1_rail_select_a_reg <= PGT_PG1_SEL_RST;
    end else if (load_default_reg) begin
      pg1_rail_select_a_reg <= cfg_sel_a_default;
    end else if (reg_req.wr_en && reg_req.addr == PGT_OFS_PG1_SEL_A) begin
      pg1_rail_select_a_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pg1_rail_select_b_reg <= PGT_PG1_SEL_RST;
    end else if (load_default_reg) begin
      pg1_rail_select_b_reg <= cfg_sel_b_default;
    end else if (reg_req.wr_en && reg_req.addr == PGT_OFS_PG1_SEL_B) begin
      pg1_rail_select_b_reg <= reg_req.wdata;
    end
  end

  // Reads answer in the next cycle; unmapped offsets read zero.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd_en;
      if (!reg_req.rd_en) begin
        reg_rdata <= 8'h00;
      end else if (reg_req.addr == PGT_OFS_FAULT_MASK_B) begin
        reg_rdata <= fault_shutdown_mask_b_reg;
      end else if (reg_req.addr == PGT_OFS_PG1_SEL_A) begin
        reg_rdata <= pg1_rail_select_a_reg;
      end else if (reg_req.addr == PGT_OFS_PG1_SEL_B) begin
        reg_rdata <= pg1_rail_select_b_reg;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  assign shared_good  = cfg_shared_is_a1 ? rail_good.linear_reg_a1
                                         : rail_good.load_switch_b2;
  assign shared_fault = cfg_shared_is_a1 ? rail_fault.linear_reg_a1
                                         : rail_fault.load_switch_b2;

  // A masked source forces its term true so it cannot pull the tree low.
  assign terms_a = {rail_good.linear_reg_a2, rail_good.load_switch_a1,
                    rail_good.step_down_rail} | pg1_rail_select_a_reg;
  assign terms_b = {control_input[3], control_input[2], control_input[1],
                    control_input[0], rail_good.ddr_term_reg, shared_good,
                    rail_good.load_switch_b1, rail_good.linear_reg_a3}
                   | pg1_rail_select_b_reg;
  assign pg_next = &{terms_a, terms_b};

  assign fault_b = {3'b000, rail_fault.linear_reg_a1, rail_fault.ddr_term_reg,
                    rail_fault.load_switch_b2, rail_fault.load_switch_b1,
                    rail_fault.linear_reg_a3};
  assign shutdown_next = |(fault_b[4:0] & ~fault_shutdown_mask_b_reg[4:0]);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pg_output_1 <= 1'b0;
    end else begin
      pg_output_1 <= pg_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_req <= 1'b0;
    end else begin
      shutdown_req <= shutdown_next;
    end
  end

  sequence s_fm_write;
    reg_req.wr_en && reg_req.addr == PGT_OFS_FAULT_MASK_B;
  endsequence

  // Writes that land in the default-load cycle are overwritten, so they are left out.
  sequence s_sel_a_write;
    !load_default_reg && reg_req.wr_en && reg_req.addr == PGT_OFS_PG1_SEL_A;
  endsequence

  sequence s_sel_b_write;
    !load_default_reg && reg_req.wr_en && reg_req.addr == PGT_OFS_PG1_SEL_B;
  endsequence

  sequence s_fm_read;
    reg_req.rd_en && reg_req.addr == PGT_OFS_FAULT_MASK_B;
  endsequence

  a_fm_bit7_zero: assert property (@(posedge clock) disable iff (!rst_n)
    fault_shutdown_mask_b_reg[PGT_FM_RSVD_RO] == 1'b0)
    else $error("fault mask bit 7 not zero");
  a_fm_write_takes: assert property (@(posedge clock) disable iff (!rst_n)
    s_fm_write |=> fault_shutdown_mask_b_reg[6:0] == $past(reg_req.wdata[6:0]))
    else $error("fault mask write lost");
  a_masked_no_shut: assert property (@(posedge clock) disable iff (!rst_n)
    (fault_shutdown_mask_b_reg[4:0] == 5'h1f) |=> !shutdown_req)
    else $error("masked fault caused shutdown");
  a_unmasked_shut: assert property (@(posedge clock) disable iff (!rst_n)
    (rail_fault.linear_reg_a3 && !fault_shutdown_mask_b_reg[PGT_FM_A3]) |=> shutdown_req)
    else $error("unmasked fault ignored");
  a_pg_all_masked: assert property (@(posedge clock) disable iff (!rst_n)
    (pg1_rail_select_a_reg == 8'hff && pg1_rail_select_b_reg == 8'hff) |=> pg_output_1)
    else $error("fully masked tree not good");
  a_ctl_term: assert property (@(posedge clock) disable iff (!rst_n)
    (!control_input[0] && !pg1_rail_select_b_reg[PGT_SB_CONTROL_INPUT_1]) |=> !pg_output_1)
    else $error("control input term ignored");
  a_rail_term: assert property (@(posedge clock) disable iff (!rst_n)
    (!rail_good.linear_reg_a2 && !pg1_rail_select_a_reg[7]) |=> !pg_output_1)
    else $error("rail a2 term ignored");
  a_shared_sel: assert property (@(posedge clock) disable iff (!rst_n)
    (!pg1_rail_select_b_reg[PGT_SB_SHARED] && cfg_shared_is_a1 &&
     !rail_good.linear_reg_a1) |=> !pg_output_1)
    else $error("shared rail not applied");
  a_shared_b2: assert property (@(posedge clock) disable iff (!rst_n)
    (!pg1_rail_select_b_reg[PGT_SB_SHARED] && !cfg_shared_is_a1 &&
     !rail_good.load_switch_b2) |=> !pg_output_1)
    else $error("shared rail b2 not applied");
  a_default_load: assert property (@(posedge clock) disable iff (!rst_n)
    load_default_reg |=> pg1_rail_select_b_reg == $past(cfg_sel_b_default))
    else $error("default not loaded");
  a_pg_good: assert property (@(posedge clock) disable iff (!rst_n)
    (&{terms_a, terms_b}) |=> pg_output_1)
    else $error("good tree not reported");
  a_pg_needs_rails: assert property (@(posedge clock) disable iff (!rst_n)
    pg_output_1 |-> $past(&(rail_good.step_down_rail | pg1_rail_select_a_reg[5:0])))
    else $error("good reported with step-down rail low");
  a_sel_a_write: assert property (@(posedge clock) disable iff (!rst_n)
    s_sel_a_write |=> pg1_rail_select_a_reg == $past(reg_req.wdata))
    else $error("select A write lost");
  a_sel_b_write: assert property (@(posedge clock) disable iff (!rst_n)
    s_sel_b_write |=> pg1_rail_select_b_reg == $past(reg_req.wdata))
    else $error("select B write lost");
  a_fm_read_back: assert property (@(posedge clock) disable iff (!rst_n)
    s_fm_read |=> reg_rvalid && reg_rdata == $past(fault_shutdown_mask_b_reg))
    else $error("fault mask read back wrong");

endmodule : pgt_tree

// File: test/pgt_host_model.sv
/*
  Host model that drives the decoded register port of the power-good tree block.
  Assumes single-cycle accesses taken on the rising edge and read data one cycle later.
*/
`timescale 1ns/1ps
module pgt_host_model
  import pgt_pkg::*;
(
  input  wire logic         clock,
  output pgt_reg_req_s      reg_req,
  input  wire logic   [7:0] reg_rdata,
  input  wire logic         reg_rvalid
);
  initial reg_req = '0;

  // Released address and data lines show the inverse of the last value.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] dd;
    dd = d;
    if (a == PGT_OFS_FAULT_MASK_B) begin
      dd[PGT_FM_RSVD6] = 1'b0;
      dd[PGT_FM_RSVD5] = 1'b1;
    end
    @(posedge clock);
    #1 reg_req <= {1'b1, 1'b0, a, dd};
    @(posedge clock);
    #1 reg_req <= {2'b00, ~a, ~dd};
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clock);
    #1 reg_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    #1 reg_req <= {2'b00, ~a, 8'hff};
    q = reg_rvalid ? reg_rdata : 8'hxx;
  endtask : rd
endmodule : pgt_host_model

// File: test/test_pg_tree_fault_mask.sv
/*
  Self-checking bench of the fault-mask and pg_output_1 source-mask registers.
  Assumes pgt_tree and the host model that speaks its register port.
*/
`timescale 1ns/1ps
module test_pg_tree_fault_mask;
  import pgt_pkg::*;
  logic         clock;
  logic         arst_n;
  pgt_reg_req_s reg_req;
  logic   [7:0] reg_rdata;
  logic         reg_rvalid;
  logic         sh_a1;
  pgt_rails_s   rail_good;
  pgt_rails_s   rail_fault;
  logic   [3:0] control_input;
  logic         pg_output_1;
  logic         shutdown_req;
  logic   [7:0] q;
  logic   [7:0] def_a;
  logic   [7:0] def_b;
  logic  [15:0] m;
  int           n_fail;
  int           compares;

  pgt_tree uut (.clock(clock), .arst_n(arst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cfg_sel_a_default(def_a),
    .cfg_sel_b_default(def_b), .cfg_shared_is_a1(sh_a1), .rail_good(rail_good),
    .rail_fault(rail_fault), .control_input(control_input),
    .pg_output_1(pg_output_1), .shutdown_req(shutdown_req));
  pgt_host_model host (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick

  // Source levels in select order; the rail not chosen for the shared bit gets the inverse.
  task automatic set_src(input logic [15:0] s);
    rail_good = {s[7:0], sh_a1 ? s[10] : ~s[10], s[11], sh_a1 ? ~s[10] : s[10],
                 s[9], s[8]};
    control_input = s[15:12];
  endtask : set_src

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end

  initial begin
    n_fail = 0;
    compares = 0;
    arst_n = 1'b0;
    sh_a1 = 1'b0;
    def_a = 8'h5a;
    def_b = 8'hc3;
    rail_good = '0;
    rail_fault = '0;
    control_input = 4'h0;
    repeat (5) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (4) tick();
    host.rd(PGT_OFS_FAULT_MASK_B, q); check(q, 8'h20);
    host.rd(PGT_OFS_PG1_SEL_A, q);    check(q, 8'h5a);
    host.rd(PGT_OFS_PG1_SEL_B, q);    check(q, 8'hc3);
    host.wr(8'ha6, 8'hff);
    host.rd(8'ha6, q);                check(q, 8'h00);
    host.wr(PGT_OFS_FAULT_MASK_B, 8'hff);
    host.rd(PGT_OFS_FAULT_MASK_B, q); check(q, 8'h3f);
    for (int i = 0; i < 5; i++) begin
      host.wr(PGT_OFS_FAULT_MASK_B, 8'h1f ^ (8'h01 << i));
      rail_fault = pgt_rails_s'(13'h1fff ^ (13'h1 << i));
      tick();                         check(8'(shutdown_req), 8'h00);
      rail_fault = pgt_rails_s'(13'h1 << i);
      tick();                         check(8'(shutdown_req), 8'h01);
    end
    for (int k = 0; k < 2; k++) begin
      sh_a1 = k[0];
      for (int j = 0; j < 16; j++) begin
        m = 16'hffff ^ (16'h1 << j);
        host.wr(PGT_OFS_PG1_SEL_A, m[7:0]);
        host.wr(PGT_OFS_PG1_SEL_B, m[15:8]);
        host.rd(PGT_OFS_PG1_SEL_B, q); check(q, m[15:8]);
        set_src(m);
        tick();                      check(8'(pg_output_1), 8'h00);
        set_src(16'hffff);
        tick();                      check(8'(pg_output_1), 8'h01);
      end
    end
    host.wr(PGT_OFS_PG1_SEL_A, 8'hff);
    host.wr(PGT_OFS_PG1_SEL_B, 8'hff);
    set_src(16'h0000);
    tick();                           check(8'(pg_output_1), 8'h01);
    // A second reset in mid-run must reload the new defaults and clear the rail masks.
    def_a = 8'h3c;
    def_b = 8'h96;
    arst_n = 1'b0;
    tick();                           check(8'(pg_output_1), 8'h00);
    check(8'(shutdown_req), 8'h00);
    arst_n = 1'b1;
    repeat (4) tick();
    host.rd(PGT_OFS_FAULT_MASK_B, q); check(q, 8'h20);
    host.rd(PGT_OFS_PG1_SEL_A, q);    check(q, 8'h3c);
    host.rd(PGT_OFS_PG1_SEL_B, q);    check(q, 8'h96);
    tick();                           check(8'(shutdown_req), 8'h01);
    end_of_test();
  end
endmodule : test_pg_tree_fault_mask
